// file: pkg/acs_pkg.sv
// Constants and types shared by the converter configuration sequencer
package acs_pkg;

   localparam int unsigned CFG_W      = 7;
   localparam int unsigned SEQ_DEPTH  = 16;
   localparam int unsigned RESULT_W   = 16;
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned SOS_SLOT   = 16;

   // Serial word handling
   localparam logic [2:0] WORD_LAST_BIT = 3'h7;
   localparam logic [4:0] SEQ_LAST_IDX  = 5'h0F;
   localparam logic [4:0] FRAME_END     = 5'h18;
   localparam logic [4:0] SOS_CNT       = 5'h10;

   // Channel codes on the multiplexer outputs, 8 is the common return input
   localparam logic [3:0] CHAN_COMMON = 4'h8;

   // Register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_CONFIG = 4'h8;

   // Control register fields and reset values
   localparam int unsigned CTRL_SER_EN_BIT  = 0;
   localparam int unsigned CTRL_RESTORE_BIT = 1;
   localparam logic        CTRL_SER_EN_RST  = 1'b1;

   // Status and config register field positions
   localparam int unsigned ST_PTR_LSB   = 0;
   localparam int unsigned ST_DEPTH_LSB = 4;
   localparam int unsigned ST_OPEN_BIT  = 9;
   localparam int unsigned ST_SOS_BIT   = 10;
   localparam int unsigned CF_USED_LSB  = 8;

   typedef enum logic [1:0] {
      RANGE_UNI_PSEUDO = 2'b00,
      RANGE_BIP_PSEUDO = 2'b01,
      RANGE_DIFF_BIN   = 2'b10,
      RANGE_DIFF_TWOS  = 2'b11
   } acs_range_t;

   typedef struct packed {
      logic [3:0] mux;
      acs_range_t range;
      logic       gain;
   } acs_cfg_t;

   localparam acs_cfg_t DEFAULT_CONFIG_WORD = 7'h00;

   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      acs_range_t range;
      logic       twos;
      logic       fully_diff;
      logic       gain;
   } acs_path_t;

endpackage

// file: src/acs_decode.sv
// Decoder from a stored configuration word to multiplexer and range settings
`timescale 1ns/1ns
module acs_decode
   import acs_pkg::*;
(
   input  wire acs_cfg_t  cfg_i,
   output acs_path_t      path_o
);

   always_comb begin
      path_o = '0;
      // Multiplexer select field, range field and gain bit see (R3)
      if (!cfg_i.mux[3]) begin
         // Adjacent pair, bit 2 picks which side is positive see (R8)
         path_o.pos = {1'b0, cfg_i.mux[1:0], cfg_i.mux[2]};
         path_o.neg = {1'b0, cfg_i.mux[1:0], ~cfg_i.mux[2]};
      end else begin
         // Single channel against the common return input see (R8)
         path_o.pos = {1'b0, cfg_i.mux[2:0]};
         path_o.neg = CHAN_COMMON;
      end
      path_o.range = cfg_i.range;
      case (cfg_i.range)
         RANGE_UNI_PSEUDO: begin // see (R4)
            path_o.twos       = 1'b0;
            path_o.fully_diff = 1'b0;
         end
         RANGE_BIP_PSEUDO: begin // see (R4)
            path_o.twos       = 1'b1;
            path_o.fully_diff = 1'b0;
         end
         RANGE_DIFF_BIN: begin // see (R5)
            path_o.twos       = 1'b0;
            path_o.fully_diff = 1'b1;
         end
         default: begin // see (R5)
            path_o.twos       = 1'b1;
            path_o.fully_diff = 1'b1;
         end
      endcase
      // Gain compression follows its bit, never in the unipolar range see (R6) see (R7)
      path_o.gain = cfg_i.gain && (cfg_i.range != RANGE_UNI_PSEUDO);
   end

endmodule

// file: src/acs_sequencer.sv
// Serial configuration decoder and sequencer with Avalon-MM register access
//
// Summary of operation
// (R1) Words enter MSB first, one bit per shift rise
// (R2) Top bit only gates sequencer programming
// (R3) Bits 6:3 mux, 2:1 range, 0 gain
// (R4) Range 00 unipolar binary, 01 bipolar twos
// (R5) Range 10 differential binary, 11 differential twos
// (R6) Gain bit: 0 off, 1 on
// (R7) Unipolar range always forces gain compression off
// (R8) Mux field picks pair or channel against common
// (R9) Positive to mux_out_pos, negative to mux_out_neg
// (R10) Sixteen stored entries of seven bits
// (R11) Stored entries applied in turn, repeating forever
// (R12) Pointer selects entry configuring the converter
// (R13) Reprogramming returns pointer to first entry
// (R14) Pointer wraps after last programmed entry
// (R15) Reset leaves single all-zero entry
// (R16) Start flag driven in seventeenth shift cycle
// (R17) Start flag set when first entry used
// (R18) Host may stop after seventeen shift cycles
// (R19) Window opens busy fall, closes busy rise
// (R20) First valid word clears, writes, applies at once
// (R21) Partial words dropped; zero top bit closes window
// (R22) Result, flag, config out; then stays low
// (R23) Pointer advances at each conversion start
// (R24) Entries persist until reset or reprogramming
`timescale 1ns/1ns
module acs_sequencer
   import acs_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rstn_i,
   input  wire logic                  ce_i,
   input  wire logic                  sclk_i,
   input  wire logic                  sdi_i,
   input  wire logic                  busy_i,
   input  wire logic [RESULT_W-1:0]   result_i,
   output logic                       sdo_o,
   output logic [3:0]                 mux_out_pos_o,
   output logic [3:0]                 mux_out_neg_o,
   output logic [1:0]                 range_o,
   output logic                       twos_comp_o,
   output logic                       fully_diff_o,
   output logic                       gain_comp_o,
   output logic                       sequence_start_flag_o,
   input  wire logic [3:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   output logic [31:0]                avs_readdata_o,
   output logic                       avs_waitrequest_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   logic sclk_s1_q, sclk_s2_q, sclk_q;
   logic sdi_s1_q, sdi_s2_q;
   logic busy_s1_q, busy_s2_q, busy_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_q    <= 1'b0;
         sdi_s1_q  <= 1'b0;
         sdi_s2_q  <= 1'b0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         busy_q    <= 1'b0;
      end else if (ce_i) begin
         sclk_s1_q <= sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_q    <= sclk_s2_q;
         sdi_s1_q  <= sdi_i;
         sdi_s2_q  <= sdi_s1_q;
         busy_s1_q <= busy_i;
         busy_s2_q <= busy_s1_q;
         busy_q    <= busy_s2_q;
      end
   end

   logic ser_en_q;
   logic restore_q;
   logic sclk_rise, busy_rise, busy_fall;

   assign sclk_rise = sclk_s2_q & ~sclk_q & ser_en_q;
   assign busy_rise = busy_s2_q & ~busy_q;
   assign busy_fall = ~busy_s2_q & busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Programming window and word assembly

   logic       open_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] word_q;
   logic [4:0] nwords_q;
   logic       prog_take, word_done;
   acs_cfg_t   new_word;

   assign prog_take = sclk_rise & open_q & ~busy_s2_q & ~busy_rise;    // see (R19)
   assign word_done = prog_take & (bit_cnt_q == WORD_LAST_BIT);        // see (R1)
   assign new_word  = acs_cfg_t'({word_q[5:0], sdi_s2_q});             // see (R2)

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         open_q    <= 1'b1;
         bit_cnt_q <= 3'h0;
         word_q    <= 7'h00;
         nwords_q  <= 5'h00;
      end else if (ce_i) begin
         if (busy_fall) begin
            // Fresh window; a partial word is dropped here see (R19) see (R21)
            open_q    <= 1'b1;
            bit_cnt_q <= 3'h0;
            nwords_q  <= 5'h00;
         end else if (busy_rise) begin
            open_q <= 1'b0; // see (R19)
         end else if (prog_take) begin
            if (bit_cnt_q == 3'h0 && !sdi_s2_q) begin
               open_q <= 1'b0; // see (R21)
            end else begin
               bit_cnt_q <= bit_cnt_q + 3'h1;
               word_q    <= {word_q[5:0], sdi_s2_q}; // see (R1)
               if (word_done) begin
                  nwords_q <= nwords_q + 5'h01;
                  if (nwords_q == SEQ_LAST_IDX) begin
                     open_q <= 1'b0; // see (R21)
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer memory and pointer

   acs_cfg_t   mem_q [SEQ_DEPTH];
   logic [4:0] depth_q;
   logic [3:0] ptr_q;
   logic       sos_q;
   acs_cfg_t   used_cfg_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < SEQ_DEPTH; i++) begin
            mem_q[i] <= DEFAULT_CONFIG_WORD; // see (R15)
         end
         depth_q    <= 5'h01; // see (R15)
         ptr_q      <= 4'h0;
         sos_q      <= 1'b1;
         used_cfg_q <= DEFAULT_CONFIG_WORD;
      end else if (ce_i) begin
         if (restore_q) begin
            mem_q[0] <= DEFAULT_CONFIG_WORD;
            depth_q  <= 5'h01;
            ptr_q    <= 4'h0;
         end else if (word_done) begin
            if (nwords_q == 5'h00) begin
               // First valid word empties the list and applies at once see (R20) see (R13)
               mem_q[0] <= new_word;
               depth_q  <= 5'h01;
               ptr_q    <= 4'h0;
            end else begin
               mem_q[nwords_q[3:0]] <= new_word; // see (R10) see (R20)
               depth_q              <= nwords_q + 5'h01;
            end
         end else if (busy_rise) begin
            // Conversion takes the current entry, then the pointer moves see (R23) see (R11)
            sos_q      <= (ptr_q == 4'h0); // see (R17)
            used_cfg_q <= mem_q[ptr_q];    // see (R12)
            if (ptr_q == 4'(depth_q - 5'h01)) begin
               ptr_q <= 4'h0; // see (R14)
            end else begin
               ptr_q <= ptr_q + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the applied entry onto the converter controls

   acs_path_t path;
   logic      sos_out_q;

   acs_decode u_decode (
      .cfg_i  (mem_q[ptr_q]),
      .path_o (path)
   );

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         mux_out_pos_o <= 4'h0;
         mux_out_neg_o <= 4'h1;
         range_o       <= RANGE_UNI_PSEUDO;
         twos_comp_o   <= 1'b0;
         fully_diff_o  <= 1'b0;
         gain_comp_o   <= 1'b0;
         sos_out_q     <= 1'b1;
      end else if (ce_i) begin
         mux_out_pos_o <= path.pos; // see (R9)
         mux_out_neg_o <= path.neg; // see (R9)
         range_o       <= path.range;
         twos_comp_o   <= path.twos;
         fully_diff_o  <= path.fully_diff;
         gain_comp_o   <= path.gain; // see (R7)
         sos_out_q     <= sos_q;
      end
   end

   assign sequence_start_flag_o = sos_out_q;

   ////////////////////////////////////////////////////////////////////////////
   // Serial output frame

   logic [FRAME_BITS-1:0] out_sh_q;
   logic [4:0]            out_cnt_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         out_sh_q  <= '0;
         out_cnt_q <= 5'h00;
      end else if (ce_i) begin
         if (busy_fall) begin
            out_sh_q  <= {result_i, sos_q, used_cfg_q}; // see (R22) see (R16)
            out_cnt_q <= 5'h00;
         end else if (sclk_rise) begin
            out_sh_q <= {out_sh_q[FRAME_BITS-2:0], 1'b0}; // see (R22)
            if (out_cnt_q != FRAME_END) begin
               out_cnt_q <= out_cnt_q + 5'h01;
            end
         end
      end
   end

   assign sdo_o = out_sh_q[FRAME_BITS-1];

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave, one wait state per access

   logic req;
   assign req = avs_read_i | avs_write_i;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
         ser_en_q          <= CTRL_SER_EN_RST;
         restore_q         <= 1'b0;
      end else if (ce_i) begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         restore_q         <= 1'b0;
         if (req && avs_waitrequest_o) begin
            avs_readdata_o <= 32'h0000_0000;
            if (avs_write_i && avs_address_i == OFS_CTRL) begin
               ser_en_q  <= avs_writedata_i[CTRL_SER_EN_BIT];
               restore_q <= avs_writedata_i[CTRL_RESTORE_BIT];
            end
            if (avs_read_i) begin
               case (avs_address_i)
                  OFS_CTRL: begin
                     avs_readdata_o[CTRL_SER_EN_BIT] <= ser_en_q;
                  end
                  OFS_STATUS: begin
                     avs_readdata_o[ST_PTR_LSB +: 4]   <= ptr_q;
                     avs_readdata_o[ST_DEPTH_LSB +: 5] <= depth_q;
                     avs_readdata_o[ST_OPEN_BIT]       <= open_q;
                     avs_readdata_o[ST_SOS_BIT]        <= sos_q;
                  end
                  OFS_CONFIG: begin
                     avs_readdata_o[CFG_W-1:0]               <= mem_q[ptr_q];
                     avs_readdata_o[CF_USED_LSB +: CFG_W]    <= used_cfg_q;
                  end
                  default: begin
                     avs_readdata_o <= 32'h0000_0000;
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_ptr_wrap_last: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R14)
      (ce_i && busy_rise && !restore_q && !word_done && ptr_q == 4'(depth_q - 5'h01)) |=> (ptr_q == 4'h0))
      else $error("pointer did not wrap after last entry");

   a_sos_first_entry: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R17)
      (ce_i && busy_rise && !restore_q && !word_done) |=> (sos_q == ($past(ptr_q) == 4'h0)))
      else $error("start flag does not match first entry use");

   a_gain_unipolar: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R7)
      gain_comp_o |-> (range_o != RANGE_UNI_PSEUDO))
      else $error("gain compression on in unipolar range");

   a_first_word_apply: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R20)
      (ce_i && word_done && !restore_q && nwords_q == 5'h00)
      |=> (ptr_q == 4'h0 && depth_q == 5'h01 && mem_q[0] == $past(new_word)))
      else $error("first valid word not applied at once");

   a_zero_top_close: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R21)
      (ce_i && prog_take && bit_cnt_q == 3'h0 && !sdi_s2_q) |=> !open_q)
      else $error("window stayed open after zero top bit");

   a_full_close: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R21)
      (ce_i && word_done && nwords_q == SEQ_LAST_IDX) |=> (!open_q && depth_q == 5'h10))
      else $error("window stayed open after sixteen words");

   a_busy_closes: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R19)
      (ce_i && busy_rise) |=> (!open_q && !word_done)[*2])
      else $error("programming accepted while busy");

   a_sdo_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R22)
      (out_cnt_q == FRAME_END) |-> !sdo_o)
      else $error("serial output not low after frame");

   a_sos_slot: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R16)
      (out_cnt_q == SOS_CNT && !busy_q) |-> (sdo_o == sos_q))
      else $error("start flag not in seventeenth slot");

   a_ptr_advance: assert property (@(posedge clk_i) disable iff (!rstn_i) // see (R23)
      (ce_i && busy_rise && !restore_q && !word_done && ptr_q != 4'(depth_q - 5'h01))
      |=> (ptr_q == $past(ptr_q) + 4'h1))
      else $error("pointer did not advance at conversion start");

endmodule

// file: dv/acs_host_model.sv
// Host controller model driving the serial link and conversion busy
`timescale 1ns/1ns
module acs_host_model
   import acs_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                sdo_i,
   output logic                     sclk_o,
   output logic                     sdi_o,
   output logic                     busy_o,
   output logic [RESULT_W-1:0]      result_o
);
   logic in_frame;
   initial begin
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      busy_o = 1'b0;
      result_o = '0;
      in_frame = 1'b0;
   end
   // Undriven data line toggles outside frames
   always @(posedge clk_i) begin
      if (!in_frame) begin
         sdi_o <= ~sdi_o;
      end
   end
   task automatic set_busy(input logic v, input logic [RESULT_W-1:0] r);
      @(posedge clk_i);
      result_o <= r;
      busy_o <= v;
   endtask
   // Shift clock idles low; n rises, capture of the first 32 output bits
   task automatic shift(input int n, input logic [127:0] b, output logic [31:0] got);
      got = '0;
      @(posedge clk_i);
      in_frame <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         sdi_o <= b[127-i];
         repeat (4) @(posedge clk_i);
         if (i < 32) begin
            got = {got[30:0], sdo_i};
         end
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      in_frame <= 1'b0;
   endtask
endmodule

// file: dv/acs_sequencer_tb.sv
// Self-checking bench for the configuration sequencer
`timescale 1ns/1ns
module acs_sequencer_tb;
   import acs_pkg::*;
   logic clk, rstn, sclk, sdi, busy, sdo, flag, twos, fd, gain, rd, wr, wtr;
   logic [15:0] result;
   logic [3:0]  pos, neg, adr;
   logic [1:0]  rng;
   logic [31:0] wd, rdd, q, seed;
   logic [6:0]  ent[$];
   logic [6:0]  used;
   logic [15:0] res;
   logic        flg;
   int          ptr, wcnt, num_errors, cmp_count;
   bit          open_w, ser_en;
   acs_sequencer acs_sequencer_i (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .sclk_i(sclk), .sdi_i(sdi),
      .busy_i(busy), .result_i(result), .sdo_o(sdo), .mux_out_pos_o(pos), .mux_out_neg_o(neg), .range_o(rng),
      .twos_comp_o(twos), .fully_diff_o(fd), .gain_comp_o(gain), .sequence_start_flag_o(flag),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdd),
      .avs_waitrequest_o(wtr));
   acs_host_model acs_host_model_i (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .sdi_o(sdi), .busy_o(busy),
      .result_o(result));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      @(posedge clk);
      while (wtr !== 1'b0 && k < 100) begin
         k++;
         @(posedge clk);
      end
      if (k == 100) begin
         check("waitrequest", 32'(wtr), 32'h0);
      end
      q = rdd;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic chk_cfg(input logic [6:0] c);
      logic [3:0] pr;
      pr = {1'b0, c[4:3], 1'b0};
      repeat (3) @(posedge clk);
      check("mux_pos", 32'(pos), 32'(c[6] ? {1'b0, c[5:3]} : pr + {3'h0, c[5]}));
      check("mux_neg", 32'(neg), 32'(c[6] ? CHAN_COMMON : pr + {3'h0, ~c[5]}));
      check("range", 32'(rng), 32'(c[2:1]));
      check("fmt", 32'({twos, fd}), 32'({c[1], c[2]}));
      check("gain", 32'(gain), 32'(c[0] & (c[2:1] != 2'b00)));
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic conv(input logic [15:0] r, input int nb, input logic [127:0] bb);
      acs_host_model_i.set_busy(1'b1, r);
      used = ent[ptr];
      flg = (ptr == 0);
      ptr = (ptr + 1) % ent.size();
      res = r;
      if (nb > 0) begin
         acs_host_model_i.shift(nb, bb, q);
      end
      repeat (20) @(posedge clk);
      chk_cfg(ent[ptr]);
      check("start_flag", 32'(flag), 32'(flg));
      acs_host_model_i.set_busy(1'b0, r);
      open_w = 1;
      wcnt = 0;
      repeat (10) @(posedge clk);
   endtask
   task automatic xfer(input int n, input logic [127:0] b);
      logic [31:0] got;
      logic [7:0]  w;
      int          k;
      k = n < 32 ? n : 32;
      acs_host_model_i.shift(n, b, got);
      if (ser_en) begin
         check("frame", got, {res, flg, used, 8'h00} >> (32 - k));
         for (int i = 0; i + 8 <= n && open_w; i += 8) begin
            w = b[127-i -: 8];
            if (!w[7]) begin
               open_w = 0;
            end else begin
               if (wcnt == 0) begin
                  ent = {};
               end
               ent.push_back(w[6:0]);
               ptr = 0;
               wcnt++;
               open_w = (wcnt < 16);
            end
         end
      end
      chk_cfg(ent[ptr]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      logic [127:0] b;
      int nw, n;
      {rstn, rd, wr, adr, wd} = '0;
      seed = 32'hB721;
      num_errors = 0;
      cmp_count = 0;
      ent = {7'h00};
      ptr = 0;
      open_w = 1;
      ser_en = 1;
      wcnt = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      chk_cfg(7'h00);
      bus(OFS_STATUS, 1'b0, '0);
      check("status", q, 32'h0000_0610);
      bus(4'hC, 1'b0, '0);
      check("unmapped", q, 32'h0);
      conv(xs(), 0, '0);
      xfer(24, '0);
      for (int t = 0; t < 6; t++) begin
         nw = (t == 4) ? 16 : 1 + xs() % 5;
         b = xs();
         for (int i = 0; i < nw; i++) begin
            b[127-8*i -: 8] = {1'b1, 7'(xs())};
         end
         n = (t == 2) ? 8 * nw + 5 : (8 * nw + 16 > 128 ? 128 : 8 * nw + 16);
         if (t == 1) begin
            b[127-8*nw] = 1'b0;
         end
         conv(xs(), t == 5 ? 8 : 0, b);
         xfer(n, b);
         for (int j = 0; j < ent.size() + 2; j++) begin
            conv(xs(), 0, '0);
            xfer(t == 3 ? 17 : 26, '0);
         end
         bus(OFS_STATUS, 1'b0, '0);
         check("ptr_depth", {23'h0, q[8:0]}, 32'({5'(ent.size()), 4'(ptr)}));
         bus(OFS_CONFIG, 1'b0, '0);
         check("config", {17'h0, q[14:0]}, 32'({used, 1'b0, ent[ptr]}));
      end
      bus(OFS_CTRL, 1'b1, 32'h0);
      ser_en = 0;
      conv(xs(), 0, '0);
      xfer(8, {8'hFF, 120'h0});
      bus(OFS_CTRL, 1'b1, 32'h3);
      ser_en = 1;
      ent = {7'h00};
      ptr = 0;
      chk_cfg(7'h00);
      tally_and_finish();
   end
endmodule
